// [rtl/pipc_regs.svh]
`ifndef PIPC_REGS_SVH
`define PIPC_REGS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define PIPC_OFS_CTL1 6'h00
`define PIPC_OFS_CTL2 6'h01
`define PIPC_OFS_CTL3 6'h02
`define PIPC_OFS_FLG1 6'h03
`define PIPC_OFS_FLG2 6'h04
`define PIPC_OFS_EN1 6'h05
`define PIPC_OFS_EN2 6'h06
`define PIPC_OFS_PR1 6'h07
`define PIPC_OFS_PR2 6'h08
`define PIPC_OFS_RCS 6'h09
`define PIPC_OFS_T0CT 6'h0A
`define PIPC_OFS_T0CN 6'h0B
// ****************************************************************
// implemented bits and reset values
// ****************************************************************
`define PIPC_MASK_CTL2 8'hF5
`define PIPC_MASK_CTL3 8'hDB
`define PIPC_MASK_P1 8'h77
`define PIPC_MASK_P1_WR 8'h47
`define PIPC_MASK_P2 8'h96
`define PIPC_MASK_RCS 8'h93
`define PIPC_RST_CTL1 8'h00
`define PIPC_RST_CTL2 8'hF5
`define PIPC_RST_CTL3 8'hC0
`define PIPC_RST_EN 8'h00
`define PIPC_RST_PR1 8'h77
`define PIPC_RST_PR2 8'h96
`define PIPC_RST_RCS 8'h10
// ****************************************************************
// field positions
// ****************************************************************
`define PIPC_B_GEN 7
`define PIPC_B_PEN 6
`define PIPC_B_T0IE 5
`define PIPC_B_I0IE 4
`define PIPC_B_PCE 3
`define PIPC_B_T0F 2
`define PIPC_B_I0F 1
`define PIPC_B_RBF 0
`define PIPC_B_EDG0 6
`define PIPC_B_EDG1 5
`define PIPC_B_EDG2 4
`define PIPC_B_T0P 2
`define PIPC_B_RBP 0
`define PIPC_B_I2P 7
`define PIPC_B_I1P 6
`define PIPC_B_I2IE 4
`define PIPC_B_I1IE 3
`define PIPC_B_I2F 1
`define PIPC_B_I1F 0
`define PIPC_B_LVL 7
`define PIPC_B_WDT 3
`define PIPC_B_PDN 2
`endif

// [rtl/pipc_pkg.sv]
package pipc_pkg;
	localparam int PIPC_PC_W = 21;
	typedef struct packed {
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [7:0] ctl3;
		logic [7:0] flg1;
		logic [7:0] flg2;
		logic [7:0] en1;
		logic [7:0] en2;
		logic [7:0] pr1;
		logic [7:0] pr2;
		logic [7:0] rcs;
		logic t0_wide;
		logic [15:0] t0_cnt;
		logic [31:0] prdata;
		logic push;
		logic [PIPC_PC_W-1:0] ret_pc;
		logic [7:0] sh_w;
		logic [7:0] sh_s;
		logic [7:0] sh_b;
	} pipc_state_t;
endpackage : pipc_pkg

// [rtl/pipc_pin_if.sv]
`timescale 1ns/10ps
interface pipc_pin_if #(parameter int W = 1);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : pipc_pin_if

// [rtl/pipc_pin_sync.sv]
`timescale 1ns/10ps
module pipc_pin_sync #(parameter int W = 1) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// raw pins
	input wire logic [W-1:0] pin,
	// filtered level and edges
	pipc_pin_if.src edges
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
		logic [W-1:0] rise;
		logic [W-1:0] fall;
		logic [1:0] fill;
	} pipc_sync_t;
	pipc_sync_t s_r;
	pipc_sync_t s_nxt;
	logic [W-1:0] agree;
	logic [W-1:0] lvl;
	logic armed;

	always_comb begin
		s_nxt = s_r;
		armed = (s_r.fill == 2'h3);
		agree = ~(s_r.s2 ^ s_r.s3);
		// until the chain is full the level just follows the pin
		lvl = armed ? ((s_r.s3 & agree) | (s_r.stable & ~agree)) : s_r.s2;
		s_nxt.s1 = pin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.stable = lvl;
		s_nxt.fill = armed ? s_r.fill : s_r.fill + 2'h1;
		// no edge while loading, so a high idle pin gives none
		s_nxt.rise = armed ? (lvl & ~s_r.stable) : '0; // RULE27
		s_nxt.fall = armed ? (~lvl & s_r.stable) : '0; // RULE27
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign edges.level = s_r.stable;
	assign edges.rise = s_r.rise;
	assign edges.fall = s_r.fall;
endmodule : pipc_pin_sync

// [rtl/pipc_top.sv]
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "pipc_regs.svh"
// Notes on behaviour
// RULE1: without priority levels, peripheral sources need peripheral enable.
// RULE2: enable register one: bits 6,5,4,2,1,0, reset zero.
// RULE3: enable register two: bits 7,4,2,1, reset zero.
// RULE4: unimplemented bits read zero and ignore writes.
// RULE5: priority register one mirrors enable one, 1 is high, reset one.
// RULE6: priority register two: bits 7,4,2,1, 1 is high, reset one.
// RULE7: priority bits matter only while priority levels are on.
// RULE8: priority-levels bit is bit 7 of reset-cause register, reset zero.
// RULE9: reset-cause flags at bits 4..0; timeout and power-down read-only.
// RULE10: external pins trigger on rising edge if select is 1, else falling.
// RULE11: valid edge sets pin flag; cleared enable blocks the request.
// RULE12: software clears the pin flag before re-enabling the interrupt.
// RULE13: enabled external pin flag wakes the sleeping core.
// RULE14: after wake, core vectors only when global enable is set.
// RULE15: pin 1 and pin 2 priority from control three bits 6 and 7.
// RULE16: pin 0 has no priority bit and is always high priority.
// RULE17: 8-bit timer mode: wrap FF to 00 sets overflow flag.
// RULE18: 16-bit timer mode: only wrap FFFF to 0000 sets the flag.
// RULE19: timer enable at control one bit 5, priority control two bit 2.
// RULE20: port pins 7..4 change sets flag bit 0; enable bit 3; prio bit 0.
// RULE21: on ack push return address and shadow working, status, bank.
// RULE22: without fast return software saves its own context.
// RULE23: flags set on their event whatever the enables are.
// RULE24: edge selects at control two bits 6,5,4, reset to rising.
// RULE25: global enable is control one bit 7.
// RULE26: with levels on, active sources request high or low by priority.
// RULE27: synchronised pins compare to previous sample, one flag per edge.
module pipc_top
	import pipc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic [2:0] ext_pin,
	input wire logic [3:0] port_hi_pin,
	// peripheral events, one-cycle pulses
	input wire logic conv_done_evt,
	input wire logic capcmp_evt,
	input wire logic tmr_b_match_evt,
	input wire logic tmr_a_ovf_evt,
	input wire logic osc_fail_evt,
	input wire logic mem_write_evt,
	input wire logic low_volt_evt,
	input wire logic tmr_c_ovf_evt,
	input wire logic tmr_z_tick,
	// peripheral levels
	input wire logic serial_rx_full,
	input wire logic serial_tx_empty,
	// reset-cause status from power logic
	input wire logic watchdog_timeout_flag,
	input wire logic power_down_flag,
	// core side
	input wire logic core_sleeping,
	input wire logic irq_ack,
	input wire logic irq_ack_high,
	input wire logic [PIPC_PC_W-1:0] return_pc,
	input wire logic [7:0] working_register,
	input wire logic [7:0] status_register,
	input wire logic [7:0] bank_select_register,
	output logic irq_high,
	output logic irq_low,
	output logic wake,
	output logic stack_push,
	output logic [PIPC_PC_W-1:0] stack_pc,
	output logic [7:0] shadow_working,
	output logic [7:0] shadow_status,
	output logic [7:0] shadow_bank
);
	pipc_state_t s_r;
	pipc_state_t s_nxt;
	pipc_pin_if #(.W(3)) ext_e ();
	pipc_pin_if #(.W(4)) port_e ();
	logic [5:0] idx;
	logic mapped;
	logic wr;
	logic [7:0] wd;
	logic [7:0] rd;
	logic [2:0] ext_hit;
	logic port_chg;
	logic t0_ovf;
	logic priority_levels_on;
	logic [4:0] core_act;
	logic [4:0] core_pr;
	logic [15:0] per_act;
	logic [15:0] per_pr;

	pipc_pin_sync #(.W(3)) u_ext_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(ext_pin),
		.edges(ext_e.src)
	);
	pipc_pin_sync #(.W(4)) u_port_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(port_hi_pin),
		.edges(port_e.src)
	);

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign idx = paddr[7:2];
	assign mapped = (paddr[1:0] == 2'h0) && (idx <= `PIPC_OFS_T0CN);
	assign wr = psel && penable && pwrite && mapped && pstrb[0];
	assign wd = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		unique case (idx)
		`PIPC_OFS_CTL1: rd = s_r.ctl1;
		`PIPC_OFS_CTL2: rd = s_r.ctl2;
		`PIPC_OFS_CTL3: rd = s_r.ctl3;
		`PIPC_OFS_FLG1: rd = s_r.flg1;
		`PIPC_OFS_FLG2: rd = s_r.flg2;
		`PIPC_OFS_EN1: rd = s_r.en1;
		`PIPC_OFS_EN2: rd = s_r.en2;
		`PIPC_OFS_PR1: rd = s_r.pr1;
		`PIPC_OFS_PR2: rd = s_r.pr2;
		`PIPC_OFS_RCS: begin
			rd = s_r.rcs; // RULE4
			rd[`PIPC_B_WDT] = watchdog_timeout_flag; // RULE9
			rd[`PIPC_B_PDN] = power_down_flag; // RULE9
		end
		`PIPC_OFS_T0CT: rd = {7'h00, s_r.t0_wide};
		`PIPC_OFS_T0CN: rd = 8'h00;
		default: rd = 8'h00;
		endcase
	end

	// ****************************************************************
	// event detection
	// ****************************************************************
	assign ext_hit[0] = s_r.ctl2[`PIPC_B_EDG0] ? ext_e.rise[0] :
		ext_e.fall[0]; // RULE10
	assign ext_hit[1] = s_r.ctl2[`PIPC_B_EDG1] ? ext_e.rise[1] :
		ext_e.fall[1]; // RULE10
	assign ext_hit[2] = s_r.ctl2[`PIPC_B_EDG2] ? ext_e.rise[2] :
		ext_e.fall[2]; // RULE10
	assign port_chg = |(port_e.rise | port_e.fall); // RULE20
	// 8-bit mode wraps on low byte, 16-bit only on full count
	assign t0_ovf = tmr_z_tick && (s_r.t0_wide ? (s_r.t0_cnt == 16'hFFFF) :
		(s_r.t0_cnt[7:0] == 8'hFF)); // RULE17 RULE18

	// ****************************************************************
	// request logic
	// ****************************************************************
	assign priority_levels_on = s_r.rcs[`PIPC_B_LVL]; // RULE8
	assign core_act = {
		s_r.ctl1[`PIPC_B_I0F] & s_r.ctl1[`PIPC_B_I0IE],
		s_r.ctl1[`PIPC_B_T0F] & s_r.ctl1[`PIPC_B_T0IE], // RULE19
		s_r.ctl1[`PIPC_B_RBF] & s_r.ctl1[`PIPC_B_PCE], // RULE20
		s_r.ctl3[`PIPC_B_I1F] & s_r.ctl3[`PIPC_B_I1IE], // RULE11
		s_r.ctl3[`PIPC_B_I2F] & s_r.ctl3[`PIPC_B_I2IE]};
	assign core_pr = {
		1'b1, // RULE16
		s_r.ctl2[`PIPC_B_T0P], // RULE19
		s_r.ctl2[`PIPC_B_RBP], // RULE20
		s_r.ctl3[`PIPC_B_I1P], // RULE15
		s_r.ctl3[`PIPC_B_I2P]}; // RULE15
	assign per_act = {s_r.flg2 & s_r.en2, s_r.flg1 & s_r.en1};
	assign per_pr = {s_r.pr2, s_r.pr1};

	always_comb begin
		if (!priority_levels_on) begin
			irq_low = 1'b0; // RULE7
			irq_high = s_r.ctl1[`PIPC_B_GEN] && ((|core_act) ||
				(s_r.ctl1[`PIPC_B_PEN] && (|per_act))); // RULE1 RULE25
		end else begin
			irq_high = s_r.ctl1[`PIPC_B_GEN] && ((|(core_act & core_pr)) ||
				(|(per_act & per_pr))); // RULE26
			irq_low = s_r.ctl1[`PIPC_B_GEN] && s_r.ctl1[`PIPC_B_PEN] &&
				((|(core_act & ~core_pr)) ||
				(|(per_act & ~per_pr))); // RULE26
		end
	end

	// wake ignores the global enable; vectoring is left to irq lines
	assign wake = core_sleeping && (core_act[4] || core_act[1] ||
		core_act[0]); // RULE13 RULE14

	// ****************************************************************
	// state update
	// ****************************************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.push = 1'b0;
		if (psel && !penable) begin
			s_nxt.prdata = (idx == `PIPC_OFS_T0CN && mapped) ?
				{16'h0000, s_r.t0_cnt} : {24'h000000, rd};
		end
		if (wr) begin
			unique case (idx)
			`PIPC_OFS_CTL1: s_nxt.ctl1 = wd; // RULE25
			`PIPC_OFS_CTL2: s_nxt.ctl2 = wd & `PIPC_MASK_CTL2; // RULE24
			`PIPC_OFS_CTL3: s_nxt.ctl3 = wd & `PIPC_MASK_CTL3; // RULE4
			`PIPC_OFS_FLG1: s_nxt.flg1 = (wd & `PIPC_MASK_P1_WR) |
				(s_r.flg1 & ~`PIPC_MASK_P1_WR);
			`PIPC_OFS_FLG2: s_nxt.flg2 = wd & `PIPC_MASK_P2;
			`PIPC_OFS_EN1: s_nxt.en1 = wd & `PIPC_MASK_P1; // RULE2
			`PIPC_OFS_EN2: s_nxt.en2 = wd & `PIPC_MASK_P2; // RULE3
			`PIPC_OFS_PR1: s_nxt.pr1 = wd & `PIPC_MASK_P1; // RULE5
			`PIPC_OFS_PR2: s_nxt.pr2 = wd & `PIPC_MASK_P2; // RULE6
			`PIPC_OFS_RCS: s_nxt.rcs = wd & `PIPC_MASK_RCS; // RULE8 RULE9
			`PIPC_OFS_T0CT: s_nxt.t0_wide = wd[0];
			`PIPC_OFS_T0CN: s_nxt.t0_wide = s_r.t0_wide;
			default: s_nxt.t0_wide = s_r.t0_wide;
			endcase
		end
		if (tmr_z_tick) begin
			s_nxt.t0_cnt[7:0] = s_r.t0_cnt[7:0] + 8'h01;
			if (s_r.t0_wide && s_r.t0_cnt[7:0] == 8'hFF) begin
				s_nxt.t0_cnt[15:8] = s_r.t0_cnt[15:8] + 8'h01;
			end
		end
		// events set after writes so a set beats a same-cycle clear
		s_nxt.ctl1[`PIPC_B_I0F] = s_nxt.ctl1[`PIPC_B_I0F] | ext_hit[0]; // RULE11
		s_nxt.ctl3[`PIPC_B_I1F] = s_nxt.ctl3[`PIPC_B_I1F] | ext_hit[1]; // RULE11
		s_nxt.ctl3[`PIPC_B_I2F] = s_nxt.ctl3[`PIPC_B_I2F] | ext_hit[2]; // RULE11
		s_nxt.ctl1[`PIPC_B_T0F] = s_nxt.ctl1[`PIPC_B_T0F] | t0_ovf; // RULE17
		s_nxt.ctl1[`PIPC_B_RBF] = s_nxt.ctl1[`PIPC_B_RBF] | port_chg; // RULE20
		s_nxt.flg1[6] = s_nxt.flg1[6] | conv_done_evt; // RULE23
		s_nxt.flg1[5] = serial_rx_full;
		s_nxt.flg1[4] = serial_tx_empty;
		s_nxt.flg1[2] = s_nxt.flg1[2] | capcmp_evt; // RULE23
		s_nxt.flg1[1] = s_nxt.flg1[1] | tmr_b_match_evt; // RULE23
		s_nxt.flg1[0] = s_nxt.flg1[0] | tmr_a_ovf_evt; // RULE23
		s_nxt.flg2[7] = s_nxt.flg2[7] | osc_fail_evt; // RULE23
		s_nxt.flg2[4] = s_nxt.flg2[4] | mem_write_evt; // RULE23
		s_nxt.flg2[2] = s_nxt.flg2[2] | low_volt_evt; // RULE23
		s_nxt.flg2[1] = s_nxt.flg2[1] | tmr_c_ovf_evt; // RULE23
		if (irq_ack) begin
			s_nxt.push = 1'b1; // RULE21
			s_nxt.ret_pc = return_pc; // RULE21
			s_nxt.sh_w = working_register; // RULE21
			s_nxt.sh_s = status_register; // RULE21
			s_nxt.sh_b = bank_select_register; // RULE21
			// taking a request masks further ones of its level
			if (!priority_levels_on || irq_ack_high) begin
				s_nxt.ctl1[`PIPC_B_GEN] = 1'b0;
			end else begin
				s_nxt.ctl1[`PIPC_B_PEN] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.ctl1 <= `PIPC_RST_CTL1;
			s_r.ctl2 <= `PIPC_RST_CTL2; // RULE24
			s_r.ctl3 <= `PIPC_RST_CTL3;
			s_r.en1 <= `PIPC_RST_EN; // RULE2
			s_r.en2 <= `PIPC_RST_EN; // RULE3
			s_r.pr1 <= `PIPC_RST_PR1; // RULE5
			s_r.pr2 <= `PIPC_RST_PR2; // RULE6
			s_r.rcs <= `PIPC_RST_RCS; // RULE8
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign stack_push = s_r.push;
	assign stack_pc = s_r.ret_pc;
	assign shadow_working = s_r.sh_w;
	assign shadow_status = s_r.sh_s;
	assign shadow_bank = s_r.sh_b;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_legacy_pen;
		!priority_levels_on && core_act == 5'h00 &&
		!s_r.ctl1[`PIPC_B_PEN] |-> !irq_high;
	endproperty
	a_legacy_pen: assert property (p_legacy_pen) // RULE1
		else $error("peripheral request passed without peripheral enable");
	property p_reserved_zero;
		psel && !penable && idx == `PIPC_OFS_EN2 && mapped
		|=> prdata[6:5] == 2'b00 && prdata[0] == 1'b0 && prdata[31:8] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // RULE4
		else $error("reserved bits read non-zero");
	property p_no_low_legacy;
		!priority_levels_on |-> !irq_low;
	endproperty
	a_no_low_legacy: assert property (p_no_low_legacy) // RULE7
		else $error("low request without priority levels");
	property p_ext_flag;
		ext_e.rise[0] && s_r.ctl2[`PIPC_B_EDG0] |=> s_r.ctl1[`PIPC_B_I0F];
	endproperty
	a_ext_flag: assert property (p_ext_flag) // RULE11
		else $error("pin 0 edge did not set its flag");
	property p_wake;
		ext_hit[1] && s_r.ctl3[`PIPC_B_I1IE] && core_sleeping ##1
		core_sleeping && s_r.ctl3[`PIPC_B_I1IE] |-> wake;
	endproperty
	a_wake: assert property (p_wake) // RULE13
		else $error("enabled pin edge did not wake core");
	property p_t0_8bit;
		!s_r.t0_wide && tmr_z_tick && s_r.t0_cnt[7:0] == 8'hFF
		|=> s_r.ctl1[`PIPC_B_T0F] && s_r.t0_cnt[7:0] == 8'h00;
	endproperty
	a_t0_8bit: assert property (p_t0_8bit) // RULE17
		else $error("8-bit wrap missed");
	property p_t0_16bit;
		s_r.t0_wide && tmr_z_tick && s_r.t0_cnt == 16'h12FF &&
		!s_r.ctl1[`PIPC_B_T0F] && !(wr && idx == `PIPC_OFS_CTL1)
		|=> !s_r.ctl1[`PIPC_B_T0F] && s_r.t0_cnt == 16'h1300;
	endproperty
	a_t0_16bit: assert property (p_t0_16bit) // RULE18
		else $error("16-bit mode flagged on low byte wrap");
	property p_push;
		irq_ack |=> stack_push && stack_pc == $past(return_pc) &&
		shadow_working == $past(working_register) ##1
		stack_push == $past(irq_ack);
	endproperty
	a_push: assert property (p_push) // RULE21
		else $error("context not saved on ack");
	property p_int0_high;
		priority_levels_on && s_r.ctl1[`PIPC_B_GEN] && core_act[4]
		|-> irq_high;
	endproperty
	a_int0_high: assert property (p_int0_high) // RULE16
		else $error("pin 0 not high priority");
	property p_poll;
		conv_done_evt |=> s_r.flg1[6];
	endproperty
	a_poll: assert property (p_poll) // RULE23
		else $error("flag not set on event");

	c_low: cover property (priority_levels_on && irq_low ##1 irq_ack);
	c_wake: cover property (core_sleeping && wake);
	c_t0: cover property (s_r.t0_wide && t0_ovf);
	c_port: cover property (port_chg ##1 s_r.ctl1[`PIPC_B_RBF]);
endmodule : pipc_top

// [verif/pipc_core_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// core side: takes requests after DLY+1 cycles of request
// ****************************************************************
module pipc_core_model
	import pipc_pkg::*;
#(parameter int DLY = 2) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control from bench
	input wire logic ack_on,
	// requests
	input wire logic irq_high,
	input wire logic irq_low,
	// take and context
	output logic irq_ack,
	output logic irq_ack_high,
	output logic [PIPC_PC_W-1:0] return_pc,
	output logic [7:0] working_register,
	output logic [7:0] status_register,
	output logic [7:0] bank_select_register
);
	logic [3:0] wait_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_r <= 4'h0;
			irq_ack <= 1'b0;
			irq_ack_high <= 1'b0;
			return_pc <= '0;
			working_register <= 8'h5A;
			status_register <= 8'hA5;
			bank_select_register <= 8'h3C;
		end else begin
			irq_ack <= 1'b0;
			if (ack_on && (irq_high || irq_low) && !irq_ack) begin
				wait_r <= wait_r + 4'h1;
				if (wait_r == DLY[3:0]) begin
					// new context on every take
					wait_r <= 4'h0;
					irq_ack <= 1'b1;
					irq_ack_high <= irq_high;
					return_pc <= return_pc + 21'h01234;
					working_register <= ~working_register;
					status_register <= status_register + 8'h11;
					bank_select_register <= bank_select_register ^ 8'h0F;
				end
			end else begin
				wait_r <= 4'h0;
			end
		end
	end
endmodule : pipc_core_model

// [verif/pipc_bench.sv]
`timescale 1ns/10ps
`include "pipc_regs.svh"
module pipc_bench;
	import pipc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready, pslverr, err;
	logic [2:0] ext_pin = 3'h0;
	logic [3:0] port_hi = 4'h0;
	logic [7:0] ev = 8'h00;
	logic tick = 1'b0;
	logic rx_full = 1'b0;
	logic pdn = 1'b0;
	logic sleeping = 1'b0;
	logic ack_on = 1'b0;
	logic irq_ack, ack_hi, irq_high, irq_low, wake, stack_push;
	logic [PIPC_PC_W-1:0] ret_pc, stack_pc;
	logic [7:0] w_reg, sreg, breg, sh_w, sh_s, sh_b;
	logic [23:0] saved = 24'h000000;
	int n_errors = 0;
	int checks_done = 0;
	logic [5:0] ra [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
		6'h06, 6'h07, 6'h08, 6'h09};
	logic [7:0] rv [10] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h77, 8'h96, 8'h18};
	logic [5:0] wa [10] = '{6'h05, 6'h06, 6'h07, 6'h07, 6'h08, 6'h08,
		6'h09, 6'h09, 6'h09, 6'h06};
	logic [7:0] wd [10] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'h00};
	logic [7:0] we [10] = '{8'h77, 8'h96, 8'h00, 8'h77, 8'h00, 8'h96,
		8'h9B, 8'h08, 8'h08, 8'h00};
	always #25 pclk = ~pclk;
	// ****************************************************************
	// design and core model
	// ****************************************************************
	pipc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_pin(ext_pin), .port_hi_pin(port_hi), .conv_done_evt(ev[0]),
		.capcmp_evt(ev[1]), .tmr_b_match_evt(ev[2]), .tmr_a_ovf_evt(ev[3]),
		.osc_fail_evt(ev[4]), .mem_write_evt(ev[5]), .low_volt_evt(ev[6]),
		.tmr_c_ovf_evt(ev[7]), .tmr_z_tick(tick), .serial_rx_full(rx_full),
		.serial_tx_empty(rx_full), .watchdog_timeout_flag(~pdn),
		.power_down_flag(pdn), .core_sleeping(sleeping), .irq_ack(irq_ack),
		.irq_ack_high(ack_hi), .return_pc(ret_pc), .working_register(w_reg),
		.status_register(sreg), .bank_select_register(breg),
		.irq_high(irq_high), .irq_low(irq_low), .wake(wake),
		.stack_push(stack_push), .stack_pc(stack_pc), .shadow_working(sh_w),
		.shadow_status(sh_s), .shadow_bank(sh_b));
	pipc_core_model #(.DLY(2)) core (.pclk(pclk), .presetn(presetn),
		.ack_on(ack_on), .irq_high(irq_high), .irq_low(irq_low),
		.irq_ack(irq_ack), .irq_ack_high(ack_hi), .return_pc(ret_pc),
		.working_register(w_reg), .status_register(sreg),
		.bank_select_register(breg));
	// ****************************************************************
	// tasks
	// ****************************************************************
	function automatic logic [7:0] ad(input logic [5:0] i);
		return {i, 2'b00};
	endfunction : ad
	task automatic results;
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		xfer(1'b1, ad(i), d);
	endtask : wr
	task automatic rd(input logic [5:0] i, input logic [31:0] e);
		xfer(1'b0, ad(i), 8'h00);
		chk("register", e, q);
	endtask : rd
	task automatic ticks(input int k);
		repeat (k) begin
			tick <= 1'b1;
			@(posedge pclk);
		end
		tick <= 1'b0;
		cyc(3);
	endtask : ticks
	task automatic take;
		int n;
		n = 0;
		chk("held", saved, {sh_w, sh_s, sh_b});
		ack_on <= 1'b1;
		while (stack_push !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		ack_on <= 1'b0;
		chk("push", 1, stack_push);
		chk("stack", ret_pc, stack_pc);
		chk("shadow", {w_reg, sreg, breg}, {sh_w, sh_s, sh_b});
		saved = {w_reg, sreg, breg};
	endtask : take
	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (90000) @(posedge pclk);
		n_errors++;
		results();
	end
	initial begin
		logic [5:0] fa;
		logic [7:0] fb, fz;
		cyc(20);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 10; i++)
			rd(ra[i], rv[i]);
		for (int i = 0; i < 10; i++) begin
			wr(wa[i], wd[i]);
			rd(wa[i], we[i]);
		end
		pdn <= 1'b1;
		rd(6'h09, 32'h04);
		xfer(1'b0, 8'h30, 8'h00);
		chk("unmapped", 1, err);
		ev <= 8'hFF;
		rx_full <= 1'b1;
		@(posedge pclk);
		ev <= 8'h00;
		cyc(2);
		rd(6'h03, 32'h77);
		rd(6'h04, 32'h96);
		wr(6'h05, 8'h40);
		wr(6'h00, 8'h80);
		chk("legacy gate", 0, {irq_high, irq_low});
		wr(6'h00, 8'hC0);
		chk("legacy req", 2, {irq_high, irq_low});
		take();
		wr(6'h09, 8'h80);
		wr(6'h07, 8'h00);
		wr(6'h00, 8'hC0);
		chk("low req", 1, {irq_high, irq_low});
		take();
		wr(6'h00, 8'hC0);
		wr(6'h07, 8'h40);
		chk("high req", 2, {irq_high, irq_low});
		wr(6'h05, 8'h00);
		chk("disabled", 0, {irq_high, irq_low});
		wr(6'h03, 8'h00);
		wr(6'h04, 8'h00);
		for (int i = 0; i < 3; i++) begin
			fa = (i == 0) ? 6'h00 : 6'h02;
			fz = (i == 0) ? 8'hC0 : 8'hC0;
			fb = (i == 1) ? 8'h01 : 8'h02;
			for (int s = 1; s >= 0; s--) begin
				wr(6'h01, s ? 8'hF5 : 8'hF5 & ~(8'h40 >> i));
				for (int l = 1; l >= 0; l--) begin
					ext_pin[i] <= l[0];
					cyc(8);
					rd(fa, fz | ((l == s) ? fb : 8'h00));
					wr(fa, fz);
				end
			end
		end
		wr(6'h01, 8'hF5);
		wr(6'h00, 8'h00);
		sleeping <= 1'b1;
		ext_pin[0] <= 1'b1;
		cyc(8);
		chk("no wake", 0, wake);
		wr(6'h00, 8'h12);
		chk("wake", 1, wake);
		chk("no vector", 0, {irq_high, irq_low});
		wr(6'h00, 8'h92);
		chk("pin0 high", 2, {irq_high, irq_low});
		wr(6'h00, 8'hC0);
		wr(6'h02, 8'h88);
		ext_pin[1] <= 1'b1;
		cyc(8);
		chk("pin1 low", 1, {irq_high, irq_low});
		chk("pin1 wake", 1, wake);
		sleeping <= 1'b0;
		wr(6'h02, 8'hC0);
		wr(6'h00, 8'h00);
		ticks(255);
		rd(6'h00, 32'h00);
		ticks(1);
		rd(6'h00, 32'h04);
		wr(6'h00, 8'h00);
		wr(6'h0A, 8'h01);
		ticks(65535);
		rd(6'h00, 32'h00);
		rd(6'h0B, 32'hFFFF);
		ticks(1);
		rd(6'h00, 32'h04);
		wr(6'h01, 8'hF1);
		wr(6'h00, 8'hE4);
		chk("t0 low", 1, {irq_high, irq_low});
		wr(6'h01, 8'hF5);
		chk("t0 high", 2, {irq_high, irq_low});
		wr(6'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			port_hi[i] <= 1'b1;
			cyc(8);
			rd(6'h00, 32'h01);
			wr(6'h00, 8'h00);
		end
		results();
	end
endmodule : pipc_bench
